// ### bench/upcs_modem_model.sv
// Modem lines and receive clock source facing the block
`timescale 1ns/1ps
module upcs_modem_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Bench control
    input wire logic baud_en,
    input wire logic ring_set,
    // Modem and receiver lines
    output logic cts_in,
    output logic dsr_in,
    output logic dcd_in,
    output logic call_alert_in,
    output logic receive_baud_clock
);
    logic [1:0] div;

    // Quarter rate keeps the receive clock well under half the system clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div <= 2'h0;
            receive_baud_clock <= 1'b0;
        end else if (baud_en) begin
            div <= div + 2'h1;
            receive_baud_clock <= div[1];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            call_alert_in <= 1'b0;
        end else begin
            call_alert_in <= ring_set;
        end
    end

    // Other modem lines held quiet so only call alert raises change bits
    assign cts_in = 1'b0;
    assign dsr_in = 1'b0;
    assign dcd_in = 1'b0;
endmodule

// ### bench/upcs_top_tb.sv
// Self-checking bench for the uart pin control and status block
`timescale 1ns/1ps
module upcs_top_tb;
    import upcs_pkg::*;
    logic ref_clk = 1'b0, arst_n = 1'b0, master_reset = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, pin_data_oe, user_output_one, user_output_two, interrupt_request_out;
    logic select_high_a = 1'b0, select_high_b = 1'b0, select_low = 1'b1;
    logic read_strobe_low = 1'b1, read_strobe_high = 1'b0;
    logic [2:0] pin_reg_sel = 3'h0;
    logic [7:0] pin_data_out, tx_data;
    logic cts_in, dsr_in, dcd_in, call_alert_in, receive_baud_clock;
    logic [7:0] rx_data_in = 8'h5a;
    logic rx_data_avail = 1'b0, rx_timeout = 1'b0, tx_take = 1'b0;
    logic [3:0] rx_error_evt = 4'h0;
    logic rx_sample_tick, rx_bit_tick, rx_data_read, tx_load, fifo_mode;
    logic baud_en = 1'b0, ring_set = 1'b0;
    int miscompares = 0, tests_run = 0, st, bt;
    logic [7:0] q;
    logic ld, rr;
    // Rows: modem control value, user output one, user output two
    localparam logic [9:0] MCR_ROWS [5] = '{10'h003, 10'h011, 10'h022, 10'h030, 10'h073};
    // Rows: ier, data avail, timeout, fifo, expected identification
    localparam logic [18:0] SRC_ROWS [4] =
        '{{8'h01, 3'b100, 8'h04}, {8'h01, 3'b011, 8'hcc}, {8'h01, 3'b010, 8'h01},
          {8'h02, 3'b000, 8'h02}};
    // Rows: select a, b, low, strobe low, strobe high, expected drive
    localparam logic [5:0] PIN_ROWS [6] =
        '{6'b110001, 6'b110111, 6'b010000, 6'b100000, 6'b111000, 6'b110100};

    always #50 ref_clk = ~ref_clk;

    upcs_top upcs_top_inst (.ref_clk(ref_clk), .arst_n(arst_n), .master_reset(master_reset),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .select_high_a(select_high_a), .select_high_b(select_high_b), .select_low(select_low),
        .read_strobe_low(read_strobe_low), .read_strobe_high(read_strobe_high),
        .pin_reg_sel(pin_reg_sel), .pin_data_out(pin_data_out), .pin_data_oe(pin_data_oe),
        .cts_in(cts_in), .dsr_in(dsr_in), .dcd_in(dcd_in), .call_alert_in(call_alert_in),
        .user_output_one(user_output_one), .user_output_two(user_output_two),
        .interrupt_request_out(interrupt_request_out), .receive_baud_clock(receive_baud_clock),
        .rx_data_in(rx_data_in), .rx_data_avail(rx_data_avail), .rx_timeout(rx_timeout),
        .rx_error_evt(rx_error_evt), .tx_take(tx_take), .rx_sample_tick(rx_sample_tick),
        .rx_bit_tick(rx_bit_tick), .rx_data_read(rx_data_read), .tx_data(tx_data),
        .tx_load(tx_load), .fifo_mode(fifo_mode));

    upcs_modem_model upcs_modem_model_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .baud_en(baud_en), .ring_set(ring_set), .cts_in(cts_in), .dsr_in(dsr_in),
        .dcd_in(dcd_in), .call_alert_in(call_alert_in), .receive_baud_clock(receive_baud_clock));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= 4'h1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: ack %h expected %h", $time, wb_ack_o, 1'b1);
        end
        q = wb_dat_o[7:0];
        ld = tx_load;
        rr = rx_data_read;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk(q & mask, exp);
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        chk({6'h0, user_output_one, user_output_two}, 8'h03);
        chk({7'h0, interrupt_request_out}, 8'h00);
        arst_n <= 1'b1;
        rd(8'h04, 8'hff, 8'h00);
        rd(8'h0c, 8'hff, 8'h00);
        rd(8'h08, 8'hff, 8'h01);
        rd(8'h18, 8'hff, 8'h00);
        rd(8'h05, 8'hff, 8'h00);
        // Sixteen samples per bit: 32 sample ticks give two bit ticks
        baud_en <= 1'b1;
        st = 0;
        bt = 0;
        for (int i = 0; i < 400 && st < 32; i++) begin
            @(posedge ref_clk);
            st += int'(rx_sample_tick);
            bt += int'(rx_bit_tick);
        end
        baud_en <= 1'b0;
        repeat (6) begin
            @(posedge ref_clk);
            bt += int'(rx_bit_tick);
        end
        chk(8'(bt), 8'h02);
        $display("reset and baud tests done");
        foreach (MCR_ROWS[i]) begin
            wb(1'b1, 8'h0c, MCR_ROWS[i][9:2]);
            repeat (2) @(posedge ref_clk);
            chk({6'h0, user_output_one, user_output_two}, {6'h0, MCR_ROWS[i][1:0]});
        end
        // Leaving loop mode; entering it fed a call alert rise and a carrier change
        wb(1'b1, 8'h0c, 8'h00);
        rd(8'h14, 8'hff, 8'h0c);
        foreach (SRC_ROWS[i]) begin
            wb(1'b1, 8'h08, {7'h0, SRC_ROWS[i][8]});
            chk({7'h0, fifo_mode}, {7'h0, SRC_ROWS[i][8]});
            wb(1'b1, 8'h04, SRC_ROWS[i][18:11]);
            rx_data_avail <= SRC_ROWS[i][10];
            rx_timeout <= SRC_ROWS[i][9];
            repeat (4) @(posedge ref_clk);
            chk({7'h0, interrupt_request_out}, {7'h0, ~SRC_ROWS[i][0]});
            rd(8'h08, 8'hff, SRC_ROWS[i][7:0]);
            rx_data_avail <= 1'b0;
            rx_timeout <= 1'b0;
            wb(1'b1, 8'h04, 8'h00);
        end
        // Transmit empty was serviced by the identification read above
        wb(1'b1, 8'h04, 8'h02);
        rd(8'h08, 8'hff, 8'h02);
        repeat (2) @(posedge ref_clk);
        chk({7'h0, interrupt_request_out}, 8'h00);
        rd(8'h08, 8'hff, 8'h01);
        wb(1'b1, 8'h04, 8'h04);
        rx_error_evt <= 4'h1;
        @(posedge ref_clk);
        rx_error_evt <= 4'h0;
        repeat (3) @(posedge ref_clk);
        chk({7'h0, interrupt_request_out}, 8'h01);
        rd(8'h08, 8'hff, 8'h06);
        rd(8'h10, 8'h1e, 8'h02);
        rd(8'h10, 8'h1e, 8'h00);
        rd(8'h00, 8'hff, 8'h5a);
        chk({7'h0, rr}, 8'h01);
        wb(1'b1, 8'h00, 8'ha5);
        chk(tx_data, 8'ha5);
        chk({7'h0, ld}, 8'h01);
        rd(8'h10, 8'h60, 8'h00);
        tx_take <= 1'b1;
        @(posedge ref_clk);
        tx_take <= 1'b0;
        rd(8'h10, 8'h60, 8'h60);
        $display("table tests done");
        wb(1'b1, 8'h04, 8'h08);
        ring_set <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk({7'h0, interrupt_request_out}, 8'h01);
        rd(8'h14, 8'h44, 8'h44);
        rd(8'h14, 8'h44, 8'h40);
        repeat (2) @(posedge ref_clk);
        chk({7'h0, interrupt_request_out}, 8'h00);
        ring_set <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rd(8'h14, 8'h44, 8'h00);
        chk({7'h0, interrupt_request_out}, 8'h00);
        $display("call alert test done");
        wb(1'b1, 8'h0c, 8'h0f);
        foreach (PIN_ROWS[i]) begin
            @(posedge ref_clk);
            pin_reg_sel <= 3'h3;
            {select_high_a, select_high_b, select_low} <= PIN_ROWS[i][5:3];
            {read_strobe_low, read_strobe_high} <= PIN_ROWS[i][2:1];
            repeat (2) @(posedge ref_clk);
            chk({7'h0, pin_data_oe}, {7'h0, PIN_ROWS[i][0]});
            if (PIN_ROWS[i][0]) chk(pin_data_out, 8'h0f);
            read_strobe_low <= 1'b1;
            read_strobe_high <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        $display("pin read test done");
        ring_set <= 1'b1;
        repeat (5) @(posedge ref_clk);
        master_reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({7'h0, interrupt_request_out}, 8'h00);
        chk({6'h0, user_output_one, user_output_two}, 8'h03);
        master_reset <= 1'b0;
        rd(8'h0c, 8'hff, 8'h00);
        rd(8'h04, 8'hff, 8'h00);
        rd(8'h14, 8'h0f, 8'h00);
        $display("master reset test done");
        report_and_stop();
    end
endmodule

// ### hw/upcs_msr_delta.sv
// Modem status levels and change detection
`timescale 1ns/1ps
module upcs_msr_delta
    import upcs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic master_reset,
    // Lines as {dcd, call alert, dsr, cts}
    input wire logic [3:0] lines,
    input wire logic clear,
    // Status
    output logic [3:0] level,
    output logic [3:0] delta
);

    logic [3:0] prev;
    logic primed;
    logic [3:0] next_delta;

    // First cycle after reset only loads the history, so no false change
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev <= 4'h0;
            primed <= 1'b0;
            level <= 4'h0;
        end else begin
            prev <= lines;
            primed <= ~master_reset;
            level <= lines;
        end
    end

    always_comb begin
        next_delta = 4'h0;
        if (primed) begin
            next_delta = lines ^ prev;
            next_delta[MSR_CALL_ALERT_TRAILING_EDGE] = lines[MSR_CALL_ALERT_TRAILING_EDGE] & ~prev[MSR_CALL_ALERT_TRAILING_EDGE];
        end
    end

    // Set wins over the read clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            delta <= 4'h0;
        end else if (master_reset) begin
            delta <= 4'h0;
        end else begin
            delta <= (clear ? 4'h0 : delta) | next_delta;
        end
    end

    sequence s_alert_rise;
        primed && !lines[MSR_CALL_ALERT_TRAILING_EDGE] && !master_reset ##1 lines[MSR_CALL_ALERT_TRAILING_EDGE] && !master_reset;
    endsequence

    a_call_alert_trailing_edge_sets: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_alert_rise |=> delta[MSR_CALL_ALERT_TRAILING_EDGE])
        else $error("call alert rise did not set edge flag");

endmodule

// ### hw/upcs_pkg.sv
// Constants and types shared by the uart pin control and status block
package upcs_pkg;

    // Byte offsets on the register bus
    localparam logic [4:0] ADDR_DATA = 5'h00;
    localparam logic [4:0] ADDR_IER = 5'h04;
    localparam logic [4:0] ADDR_IIR = 5'h08;
    localparam logic [4:0] ADDR_MCR = 5'h0c;
    localparam logic [4:0] ADDR_LSR = 5'h10;
    localparam logic [4:0] ADDR_MSR = 5'h14;

    // Interrupt enable fields
    localparam int IER_RDA = 0;
    localparam int IER_THRE = 1;
    localparam int IER_RLS = 2;
    localparam int IER_MSI = 3;

    // Modem control fields
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_USER_OUTPUT_ONE = 2;
    localparam int MCR_USER_OUTPUT_TWO = 3;
    localparam int MCR_LOOP = 4;

    // Modem status: change bits low nibble, levels high nibble
    localparam int MSR_CALL_ALERT_TRAILING_EDGE = 2;
    localparam int MSR_RI = 6;
    localparam int MSR_LEVEL_LSB = 4;

    // Fifo control field
    localparam int FCR_ENABLE = 0;

    // Interrupt identification codes, bit 0 low means pending
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_RLS = 4'h6;
    localparam logic [3:0] IIR_RDA = 4'h4;
    localparam logic [3:0] IIR_CTO = 4'hc;
    localparam logic [3:0] IIR_THRE = 4'h2;
    localparam logic [3:0] IIR_MSI = 4'h0;

    // Values after reset
    localparam logic [3:0] IER_RST = 4'h0;
    localparam logic [4:0] MCR_RST = 5'h00;
    localparam logic [3:0] LSR_ERR_RST = 4'h0;
    localparam logic [7:0] THR_RST = 8'h00;

    // Receive clock oversampling
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] OVS_LAST = 4'(OVERSAMPLE - 1);

    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_LINE,
        SRC_RXDATA,
        SRC_TIMEOUT,
        SRC_TXEMPTY,
        SRC_MODEM
    } upcs_src_t;

endpackage

// ### hw/upcs_top.sv
// Uart pin control and status: interrupt, user outputs, read pins, modem status
`timescale 1ns/1ps
module upcs_top
    import upcs_pkg::*;
(
    // Clock and resets
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic master_reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pin-level read port
    input wire logic select_high_a,
    input wire logic select_high_b,
    input wire logic select_low,
    input wire logic read_strobe_low,
    input wire logic read_strobe_high,
    input wire logic [2:0] pin_reg_sel,
    output logic [7:0] pin_data_out,
    output logic pin_data_oe,
    // Modem side
    input wire logic cts_in,
    input wire logic dsr_in,
    input wire logic dcd_in,
    input wire logic call_alert_in,
    output logic user_output_one,
    output logic user_output_two,
    output logic interrupt_request_out,
    // Receiver and transmitter sections
    input wire logic receive_baud_clock,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_data_avail,
    input wire logic rx_timeout,
    input wire logic [3:0] rx_error_evt,
    input wire logic tx_take,
    output logic rx_sample_tick,
    output logic rx_bit_tick,
    output logic rx_data_read,
    output logic [7:0] tx_data,
    output logic tx_load,
    output logic fifo_mode
);

    logic [3:0] ier;
    logic [4:0] modem_control_register;
    logic [3:0] lsr_err;
    logic thr_empty;
    logic thre_pend;
    logic [3:0] msr_level;
    logic [3:0] msr_delta;
    logic [3:0] modem_lines;
    logic [3:0] iir_code;
    upcs_src_t src;
    logic irq_pending;
    logic wb_req;
    logic wb_addr_ok;
    logic wb_rd;
    logic wb_wr;
    logic pin_selected;
    logic pin_rd;
    logic pin_rd_q;
    logic pin_start;
    logic [4:0] pin_addr;
    logic [7:0] pin_value;
    logic rd_lsr;
    logic rd_msr;
    logic rd_iir;
    logic rd_data;
    logic loop;
    logic rbc_q;
    logic rbc_rise;
    logic [3:0] ovs_cnt;

    function automatic logic wr_to(input logic [4:0] a);
        wr_to = wb_wr && wb_adr_i[4:0] == a;
    endfunction

    // Read with side effect from either the bus or the pins
    function automatic logic read_of(input logic [4:0] a);
        read_of = (wb_rd && wb_addr_ok && wb_adr_i[4:0] == a) || (pin_start && pin_addr == a);
    endfunction

    function automatic logic [7:0] reg_value(input logic [4:0] a);
        case (a)
            ADDR_DATA: reg_value = rx_data_in;
            ADDR_IER: reg_value = {4'h0, ier};
            ADDR_IIR: reg_value = {{2{fifo_mode}}, 2'b00, iir_code};
            ADDR_MCR: reg_value = {3'h0, modem_control_register};
            ADDR_LSR: reg_value = {1'b0, thr_empty, thr_empty, lsr_err, rx_data_avail};
            ADDR_MSR: reg_value = {msr_level, msr_delta};
            default: reg_value = 8'h00;
        endcase
    endfunction

    assign loop = modem_control_register[MCR_LOOP];
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_addr_ok = wb_adr_i[7:5] == 3'h0 && wb_adr_i[1:0] == 2'b00;
    assign wb_rd = wb_req & ~wb_we_i;
    assign wb_wr = wb_req & wb_we_i & wb_sel_i[0] & wb_addr_ok;

    assign pin_selected = select_high_a & select_high_b & ~select_low;
    assign pin_rd = pin_selected & (~read_strobe_low | read_strobe_high);
    assign pin_start = pin_rd & ~pin_rd_q;
    assign pin_addr = {pin_reg_sel, 2'b00};
    assign pin_value = reg_value(pin_addr);

    assign rd_lsr = read_of(ADDR_LSR);
    assign rd_msr = read_of(ADDR_MSR);
    assign rd_iir = read_of(ADDR_IIR);
    assign rd_data = read_of(ADDR_DATA);

    // Loop mode feeds the modem inputs from the control bits
    assign modem_lines = loop ? {modem_control_register[MCR_USER_OUTPUT_TWO], modem_control_register[MCR_USER_OUTPUT_ONE], modem_control_register[MCR_DTR], modem_control_register[MCR_RTS]}
                              : {dcd_in, call_alert_in, dsr_in, cts_in};

    upcs_msr_delta u_msr (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .master_reset(master_reset),
        .lines(modem_lines),
        .clear(rd_msr),
        .level(msr_level),
        .delta(msr_delta)
    );

    // Interrupt priority: line error, receive data, timeout, transmit empty, modem
    always_comb begin
        if (ier[IER_RLS] && |lsr_err) begin
            src = SRC_LINE;
        end else if (ier[IER_RDA] && rx_data_avail) begin
            src = SRC_RXDATA;
        end else if (ier[IER_RDA] && fifo_mode && rx_timeout) begin
            src = SRC_TIMEOUT;
        end else if (ier[IER_THRE] && thre_pend) begin
            src = SRC_TXEMPTY;
        end else if (ier[IER_MSI] && |msr_delta) begin
            src = SRC_MODEM;
        end else begin
            src = SRC_NONE;
        end
    end

    always_comb begin
        case (src)
            SRC_LINE: iir_code = IIR_RLS;
            SRC_RXDATA: iir_code = IIR_RDA;
            SRC_TIMEOUT: iir_code = IIR_CTO;
            SRC_TXEMPTY: iir_code = IIR_THRE;
            SRC_MODEM: iir_code = IIR_MSI;
            default: iir_code = IIR_NONE;
        endcase
    end

    assign irq_pending = src != SRC_NONE;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_request_out <= 1'b0;
        end else begin
            interrupt_request_out <= irq_pending & ~master_reset;
        end
    end

    // Wishbone answer one cycle after the request
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_rd) begin
                wb_dat_o <= wb_addr_ok ? {24'h0, reg_value(wb_adr_i[4:0])} : 32'h0;
            end
        end
    end

    // Pin read data stays driven while the strobe is held
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_rd_q <= 1'b0;
            pin_data_out <= 8'h00;
            pin_data_oe <= 1'b0;
        end else begin
            pin_rd_q <= pin_rd;
            pin_data_oe <= pin_rd;
            pin_data_out <= pin_rd ? pin_value : 8'h00;
        end
    end

    // Control registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ier <= IER_RST;
            modem_control_register <= MCR_RST;
            fifo_mode <= 1'b0;
        end else if (master_reset) begin
            ier <= IER_RST;
            modem_control_register <= MCR_RST;
            fifo_mode <= 1'b0;
        end else begin
            if (wr_to(ADDR_IER)) begin
                ier <= wb_dat_i[3:0];
            end
            if (wr_to(ADDR_MCR)) begin
                modem_control_register <= wb_dat_i[4:0];
            end
            if (wr_to(ADDR_IIR)) begin
                fifo_mode <= wb_dat_i[FCR_ENABLE];
            end
        end
    end

    // User outputs are active low and parked high in loop mode
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            user_output_one <= 1'b1;
            user_output_two <= 1'b1;
        end else if (master_reset) begin
            user_output_one <= 1'b1;
            user_output_two <= 1'b1;
        end else begin
            user_output_one <= ~(modem_control_register[MCR_USER_OUTPUT_ONE] & ~loop);
            user_output_two <= ~(modem_control_register[MCR_USER_OUTPUT_TWO] & ~loop);
        end
    end

    // Line errors stick until the line status is read; a new error wins
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lsr_err <= LSR_ERR_RST;
        end else if (master_reset) begin
            lsr_err <= LSR_ERR_RST;
        end else begin
            lsr_err <= (rd_lsr ? 4'h0 : lsr_err) | rx_error_evt;
        end
    end

    // Transmit holding register and its empty interrupt
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_data <= THR_RST;
            tx_load <= 1'b0;
            thr_empty <= 1'b1;
            thre_pend <= 1'b0;
        end else if (master_reset) begin
            tx_data <= THR_RST;
            tx_load <= 1'b0;
            thr_empty <= 1'b1;
            thre_pend <= 1'b0;
        end else begin
            tx_load <= wr_to(ADDR_DATA);
            if (wr_to(ADDR_DATA)) begin
                tx_data <= wb_dat_i[7:0];
                thr_empty <= 1'b0;
            end else if (tx_take) begin
                thr_empty <= 1'b1;
            end
            // Emptying without a data write, or enabling while empty, wins over the clear
            if ((tx_take && !wr_to(ADDR_DATA)) ||
                (wr_to(ADDR_IER) && wb_dat_i[IER_THRE] && !ier[IER_THRE] && thr_empty)) begin
                thre_pend <= 1'b1;
            end else if (wr_to(ADDR_DATA) || (rd_iir && src == SRC_TXEMPTY)) begin
                thre_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_data_read <= 1'b0;
        end else begin
            rx_data_read <= rd_data & ~master_reset;
        end
    end

    // Receive clock is sampled; one tick per rising edge, bit tick every sixteen
    assign rbc_rise = receive_baud_clock & ~rbc_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rbc_q <= 1'b0;
            ovs_cnt <= 4'h0;
            rx_sample_tick <= 1'b0;
            rx_bit_tick <= 1'b0;
        end else begin
            rbc_q <= receive_baud_clock;
            rx_sample_tick <= rbc_rise & ~master_reset;
            rx_bit_tick <= rbc_rise & ~master_reset & (ovs_cnt == OVS_LAST);
            if (master_reset) begin
                ovs_cnt <= 4'h0;
            end else if (rbc_rise) begin
                ovs_cnt <= ovs_cnt + 4'h1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_alert_rise;
        !loop && !call_alert_in ##1 !loop && call_alert_in;
    endsequence

    a_irq_follows: assert property (irq_pending && !master_reset |=> interrupt_request_out)
        else $error("pending interrupt not signalled");
    a_irq_serviced: assert property (!irq_pending |=> !interrupt_request_out)
        else $error("interrupt stayed high after service");
    a_reset_drops_irq: assert property (master_reset |=>
        !interrupt_request_out ##0 ier == IER_RST)
        else $error("master reset did not clear interrupt");
    a_line_first: assert property (ier[IER_RLS] && |lsr_err |-> iir_code == IIR_RLS)
        else $error("line error not highest priority");
    a_reset_outs: assert property (master_reset |=>
        user_output_one && user_output_two && modem_control_register == MCR_RST)
        else $error("outputs not at reset level");
    a_out_active: assert property (modem_control_register[MCR_USER_OUTPUT_ONE] && !loop && !master_reset |=> !user_output_one)
        else $error("user output one not driven low");
    a_out_two: assert property (!modem_control_register[MCR_USER_OUTPUT_TWO] || loop |=> user_output_two)
        else $error("user output two not parked high");
    a_sample_tick: assert property (!receive_baud_clock && !master_reset ##1
        receive_baud_clock && !master_reset |=> rx_sample_tick)
        else $error("baud clock edge missed");
    a_pin_read: assert property (pin_rd |=> pin_data_oe && pin_data_out == $past(pin_value))
        else $error("pin read data wrong");
    a_pin_idle: assert property (!pin_selected |=> !pin_data_oe)
        else $error("pins driven while unselected");
    a_ri_level: assert property (!loop |=>
        msr_level[MSR_RI - MSR_LEVEL_LSB] == $past(call_alert_in))
        else $error("call alert level not shown");
    a_ri_irq: assert property (s_alert_rise ##0 ier[IER_MSI] && !master_reset &&
        $past(!master_reset) ##1 !master_reset && !rd_msr |=> interrupt_request_out)
        else $error("call alert rise raised no interrupt");
    a_msr_clear: assert property (rd_msr && modem_lines == u_msr.prev |=> msr_delta == 4'h0)
        else $error("status read left change bits");
    // Strobes toward the line logic stay quiet through master reset
    a_reset_ticks: assert property (master_reset |=>
        !rx_sample_tick && !rx_bit_tick && !tx_load && !rx_data_read)
        else $error("strobes active after master reset");
    a_thre_set: assert property (tx_take && !wr_to(ADDR_DATA) && !master_reset |=> thre_pend)
        else $error("transmit empty not flagged");

endmodule
